// file: verilog/apfc_pkg.sv
package apfc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FLAG0 = 6'h17;
  localparam logic [5:0] IDX_FLAG1 = 6'h18;
  localparam logic [5:0] IDX_FLAG2 = 6'h1A;
  localparam logic [5:0] IDX_TXFMT = 6'h1B;
  localparam logic [5:0] IDX_RXFMT = 6'h1C;
  localparam logic [5:0] IDX_RDBK  = 6'h1D;
  localparam logic [5:0] IDX_ISTAT = 6'h20;
  localparam logic [5:0] IDX_IMASK = 6'h21;
  localparam logic [5:0] IDX_RDATA = 6'h22;

  // Reset values
  localparam logic [7:0] RST_FLAG0 = 8'h00;
  localparam logic [7:0] RST_FLAG1 = 8'h07;
  localparam logic [7:0] RST_FLAG2 = 8'h40;
  localparam logic [7:0] RST_TXFMT = 8'h06;
  localparam logic [7:0] RST_RXFMT = 8'h06;
  localparam logic [7:0] RST_RDBK  = 8'h80;

  // Writable bits of each register
  localparam logic [7:0] MSK_FLAG0 = 8'h0F;
  localparam logic [7:0] MSK_FLAG1 = 8'h0F;
  localparam logic [7:0] MSK_FLAG2 = 8'hF0;
  localparam logic [7:0] MSK_TXFMT = 8'h3F;
  localparam logic [7:0] MSK_RXFMT = 8'hFF;
  localparam logic [7:0] MSK_RDBK  = 8'hDF;

  // Audio port register fields
  localparam int FMT_LSB   = 0;
  localparam int WL_LSB    = 2;
  localparam int BCP_BIT   = 4;
  localparam int LRP_BIT   = 5;
  localparam int MS_BIT    = 6;
  localparam int CLKEN_BIT = 7;
  localparam logic [1:0] FMT_DSP = 2'h3;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h0;
  localparam logic [1:0] WL_16   = 2'h0;
  localparam logic [1:0] WL_20   = 2'h1;
  localparam logic [4:0] WB_16   = 5'h10;
  localparam logic [4:0] WB_20   = 5'h14;
  localparam logic [4:0] WB_24   = 5'h18;

  // Readback register fields
  localparam int SEL_LSB    = 0;
  localparam int CONTINUOUS_READBACK_BIT   = 3;
  localparam int FLAGS_BIT  = 4;
  localparam int TRMASK_BIT = 6;
  localparam int HIRATE_BIT = 7;
  localparam logic [2:0] SEL_MAX = 3'h6;

  // Flag pin selectors
  localparam int SEL0_LSB = 0;
  localparam int SEL2_LSB = 4;
  localparam int NFLAGS   = 13;
  localparam logic [3:0] FSEL_MAX = 4'hC;
  localparam int FLG_CHANNEL_STATUS_UPDATE_FLAG = 9;

  // Interrupt status bits
  localparam int IRQ_W       = 2;
  localparam int IRQ_SRCLOST = 0;
  localparam int IRQ_CSUPD   = 1;

  localparam int SAMPLE_W = 24;
  localparam logic [23:0] SAMPLE_ALL = 24'hFFFFFF;

  // Sample width of a word length code
  function automatic logic [4:0] wl_bits(input logic [1:0] wl);
    if (wl == WL_16)
      return WB_16;
    else if (wl == WL_20)
      return WB_20;
    return WB_24;
  endfunction : wl_bits
endpackage : apfc_pkg

// file: verilog/apfc_flag_if.sv
interface apfc_flag_if;
  logic [12:0] flags;
  logic [3:0]  sel0;
  logic [3:0]  sel1;
  logic [3:0]  sel2;
  logic        two_wire;
  logic [2:0]  pin;
  logic [2:0]  oe;
  modport src (output flags, sel0, sel1, sel2, two_wire, input pin, oe);
  modport mux (input flags, sel0, sel1, sel2, two_wire, output pin, oe);
endinterface : apfc_flag_if

// file: verilog/apfc_flag_mux.sv
module apfc_flag_mux (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Flags and selectors
  apfc_flag_if.mux   fi
);
  logic [2:0] pin_r;
  logic [2:0] oe_r;

  // Codes past the last flag give a steady low
  function automatic logic pick(input logic [3:0] sel, input logic [12:0] f);
    if (sel <= apfc_pkg::FSEL_MAX)
      return f[sel];
    return 1'b0;
  endfunction : pick

  // Pins 1 and 2 serve as control pins outside two-wire mode, so stay undriven
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_r <= 3'h0;
      oe_r  <= 3'h0;
    end
    else
    begin
      pin_r[0] <= pick(fi.sel0, fi.flags);
      pin_r[1] <= fi.two_wire & pick(fi.sel1, fi.flags);
      pin_r[2] <= fi.two_wire & pick(fi.sel2, fi.flags);
      oe_r     <= {fi.two_wire, fi.two_wire, 1'b1};
    end
  end

  assign fi.pin = pin_r;
  assign fi.oe  = oe_r;

  high_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    fi.sel0 > apfc_pkg::FSEL_MAX |=> !fi.pin[0])
    else $error("flag pin 0 not low for unused code");
  sel_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    fi.sel0 == 4'h7 |=> fi.pin[0] == $past(fi.flags[7]))
    else $error("flag pin 0 does not follow selected flag");
  mode_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !fi.two_wire |=> fi.pin[2:1] == 2'h0 && fi.oe[2:1] == 2'h0)
    else $error("pins 1 and 2 active outside two-wire mode");
endmodule : apfc_flag_mux

// file: verilog/apfc_top.sv
// Function
// - Four-bit selector routes a receiver flag to pin
// - Pins 1 and 2 only in two-wire mode
// - Two-bit port format field, resets to I2S
// - Word length 16, 20 or 24 bits
// - Bit 4 inverts port bit clock
// - Bit 5 frame polarity or DSP variant
// - Master bit decides who drives audio clocks
// - Clock enable keeps master clocks on loss
// - Selector picks status register for readback
// - Bit 3 enables continuous readback
// - Bit 4 appends flags to audio
// - Bit 6 disables received sample truncation
// - High-rate receive enable, set at reset
//
// Design decision made here: the Avalon-MM register port.
module apfc_top (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Interrupt
  output logic             IRQ,
  // Receiver side, flags and loss are asynchronous
  input  wire logic [12:0] RX_FLAGS,
  input  wire logic        RX_SRC_LOST,
  input  wire logic [55:0] RX_STATUS,
  input  wire logic [4:0]  CS_WORD_BITS,
  input  wire logic [23:0] RX_SAMPLE_IN,
  input  wire logic        RX_SAMPLE_VALID,
  // Control mode strap
  input  wire logic        CTRL_TWO_WIRE,
  // Internal clock generator
  input  wire logic        BCLK_GEN,
  input  wire logic        LRCLK_GEN,
  // Audio clock pins
  input  wire logic        BCLK_I,
  output logic             BCLK_O,
  output logic             BCLK_OE,
  input  wire logic        LRCLK_I,
  output logic             LRCLK_O,
  output logic             LRCLK_OE,
  // Flag pins
  output logic      [2:0]  GPO_O,
  output logic      [2:0]  GPO_OE,
  // Transmit port setup
  output logic      [1:0]  TX_FORMAT,
  output logic      [4:0]  TX_WORD_BITS,
  output logic             TX_BCLK,
  output logic             TX_LRCLK,
  output logic             TX_DSP_B,
  // Receive port setup
  output logic      [1:0]  RX_FORMAT,
  output logic      [4:0]  RX_WORD_BITS,
  output logic             RX_BCLK,
  output logic             RX_LRCLK,
  output logic             RX_DSP_B,
  // Readback and receiver modes
  output logic             CONTINUOUS_READBACK_READBACK,
  output logic             FLAGS_APPEND,
  output logic             HIGH_RATE_EN,
  output logic      [23:0] RX_SAMPLE_OUT,
  output logic             RX_SAMPLE_OUT_VALID
);
  logic [7:0]  flag0_r;
  logic [7:0]  flag1_r;
  logic [7:0]  flag2_r;
  logic [7:0]  txfmt_r;
  logic [7:0]  rxfmt_r;
  logic [7:0]  rdbk_r;
  logic [1:0]  istat_r;
  logic [1:0]  istat_nxt;
  logic [1:0]  imask_r;
  logic [1:0]  ievt;
  logic        ack_r;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic [5:0]  idx;
  logic [31:0] rdata_r;
  logic [16:0] sync1_r;
  logic [16:0] sync2_r;
  logic        lost_d_r;
  logic        channel_status_update_flag_d_r;
  logic        master;
  logic        src_lost;
  logic        raw_b;
  logic        raw_lr;
  logic        bclk_o_r;
  logic        lrclk_o_r;
  logic        clk_oe_r;
  logic        tx_b_r;
  logic        tx_lr_r;
  logic        rx_b_r;
  logic        rx_lr_r;
  logic [23:0] smp_r;
  logic        smp_v_r;

  apfc_flag_if fif ();

  // Bus handshake: one wait cycle, then the access completes
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign acc             = req & ack_r;
  assign wr_acc          = acc & AVS_WRITE & AVS_BYTEENABLE[0];
  assign idx             = AVS_ADDRESS[7:2];

  // Register view; unmapped and unused bits read zero
  function automatic logic [7:0] rd_val(input logic [5:0] a);
    if (a == apfc_pkg::IDX_FLAG0)
      return flag0_r;
    else if (a == apfc_pkg::IDX_FLAG1)
      return flag1_r;
    else if (a == apfc_pkg::IDX_FLAG2)
      return flag2_r;
    else if (a == apfc_pkg::IDX_TXFMT)
      return txfmt_r;
    else if (a == apfc_pkg::IDX_RXFMT)
      return rxfmt_r;
    else if (a == apfc_pkg::IDX_RDBK)
      return rdbk_r;
    else if (a == apfc_pkg::IDX_ISTAT)
      return {6'h00, istat_r};
    else if (a == apfc_pkg::IDX_IMASK)
      return {6'h00, imask_r};
    else if (a == apfc_pkg::IDX_RDATA)
    begin
      if (rdbk_r[2:0] <= apfc_pkg::SEL_MAX)
        return RX_STATUS[rdbk_r[2:0] * 8 +: 8];
      return 8'h00;
    end
    return 8'h00;
  endfunction : rd_val

  // Sample keep mask, MSB aligned; zero or full width keeps all bits
  function automatic logic [23:0] keep_mask(input logic [4:0] bits);
    logic [23:0] m;
    m = apfc_pkg::SAMPLE_ALL;
    if (bits != 5'h00 && bits < apfc_pkg::WB_24)
      m = apfc_pkg::SAMPLE_ALL << (apfc_pkg::WB_24 - bits);
    return m;
  endfunction : keep_mask

  // Read data is captured in the wait cycle and held through the accept edge
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (AVS_READ && !ack_r)
        rdata_r <= {24'h000000, rd_val(idx)};
    end
  end

  assign AVS_READDATA = rdata_r;

  // Configuration registers; only writable bits are stored
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      flag0_r <= apfc_pkg::RST_FLAG0;
      flag1_r <= apfc_pkg::RST_FLAG1;
      flag2_r <= apfc_pkg::RST_FLAG2;
      txfmt_r <= apfc_pkg::RST_TXFMT;
      rxfmt_r <= apfc_pkg::RST_RXFMT;
      rdbk_r  <= apfc_pkg::RST_RDBK;
      imask_r <= 2'h0;
    end
    else if (wr_acc)
    begin
      if (idx == apfc_pkg::IDX_FLAG0)
        flag0_r <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_FLAG0;
      else if (idx == apfc_pkg::IDX_FLAG1)
        flag1_r <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_FLAG1;
      else if (idx == apfc_pkg::IDX_FLAG2)
        flag2_r <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_FLAG2;
      else if (idx == apfc_pkg::IDX_TXFMT)
        txfmt_r <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_TXFMT;
      else if (idx == apfc_pkg::IDX_RXFMT)
        rxfmt_r <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_RXFMT;
      else if (idx == apfc_pkg::IDX_RDBK)
        rdbk_r  <= AVS_WRITEDATA[7:0] & apfc_pkg::MSK_RDBK;
      else if (idx == apfc_pkg::IDX_IMASK)
        imask_r <= AVS_WRITEDATA[1:0];
    end
  end

  // Two-stage synchronisers for pins and asynchronous receiver levels
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1_r <= 17'h00000;
      sync2_r <= 17'h00000;
    end
    else
    begin
      sync1_r <= {LRCLK_I, BCLK_I, CTRL_TWO_WIRE, RX_SRC_LOST, RX_FLAGS};
      sync2_r <= sync1_r;
    end
  end

  assign src_lost = sync2_r[13];

  // Interrupt events: source loss and channel status update, on rising edge
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      lost_d_r <= 1'b0;
      channel_status_update_flag_d_r <= 1'b0;
    end
    else
    begin
      lost_d_r <= src_lost;
      channel_status_update_flag_d_r <= sync2_r[apfc_pkg::FLG_CHANNEL_STATUS_UPDATE_FLAG];
    end
  end

  assign ievt[apfc_pkg::IRQ_SRCLOST] = src_lost & ~lost_d_r;
  assign ievt[apfc_pkg::IRQ_CSUPD]   = sync2_r[apfc_pkg::FLG_CHANNEL_STATUS_UPDATE_FLAG] & ~channel_status_update_flag_d_r;

  // Write one to clear; a new event in the same cycle keeps the bit set
  always_comb
  begin
    istat_nxt = istat_r;
    if (wr_acc && idx == apfc_pkg::IDX_ISTAT)
      istat_nxt = istat_r & ~AVS_WRITEDATA[1:0];
    istat_nxt = istat_nxt | ievt;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      istat_r <= 2'h0;
    else
      istat_r <= istat_nxt;
  end

  assign IRQ = |(istat_r & imask_r);

  // Master uses the generator, slave follows the synchronised pins
  assign master = rxfmt_r[apfc_pkg::MS_BIT];
  assign raw_b  = master ? BCLK_GEN : sync2_r[15];
  assign raw_lr = master ? LRCLK_GEN : sync2_r[16];

  // Pins drive the plain generator clocks; each port applies its own polarity
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      bclk_o_r  <= 1'b0;
      lrclk_o_r <= 1'b0;
      clk_oe_r  <= 1'b0;
    end
    else
    begin
      bclk_o_r  <= BCLK_GEN;
      lrclk_o_r <= LRCLK_GEN;
      clk_oe_r  <= master & (~src_lost | rxfmt_r[apfc_pkg::CLKEN_BIT]);
    end
  end

  assign BCLK_O   = bclk_o_r;
  assign LRCLK_O  = lrclk_o_r;
  assign BCLK_OE  = clk_oe_r;
  assign LRCLK_OE = clk_oe_r;

  // Port clocks; frame inversion does not apply in DSP framing
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      tx_b_r  <= 1'b0;
      tx_lr_r <= 1'b0;
      rx_b_r  <= 1'b0;
      rx_lr_r <= 1'b0;
    end
    else
    begin
      tx_b_r  <= raw_b ^ txfmt_r[apfc_pkg::BCP_BIT];
      rx_b_r  <= raw_b ^ rxfmt_r[apfc_pkg::BCP_BIT];
      tx_lr_r <= raw_lr ^ (txfmt_r[apfc_pkg::LRP_BIT] & (TX_FORMAT != apfc_pkg::FMT_DSP));
      rx_lr_r <= raw_lr ^ (rxfmt_r[apfc_pkg::LRP_BIT] & (RX_FORMAT != apfc_pkg::FMT_DSP));
    end
  end

  assign TX_BCLK  = tx_b_r;
  assign TX_LRCLK = tx_lr_r;
  assign RX_BCLK  = rx_b_r;
  assign RX_LRCLK = rx_lr_r;

  // Port format fields
  assign TX_FORMAT    = txfmt_r[apfc_pkg::FMT_LSB +: 2];
  assign RX_FORMAT    = rxfmt_r[apfc_pkg::FMT_LSB +: 2];
  assign TX_WORD_BITS = apfc_pkg::wl_bits(txfmt_r[apfc_pkg::WL_LSB +: 2]);
  assign RX_WORD_BITS = apfc_pkg::wl_bits(rxfmt_r[apfc_pkg::WL_LSB +: 2]);
  assign TX_DSP_B     = (TX_FORMAT == apfc_pkg::FMT_DSP) & txfmt_r[apfc_pkg::LRP_BIT];
  assign RX_DSP_B     = (RX_FORMAT == apfc_pkg::FMT_DSP) & rxfmt_r[apfc_pkg::LRP_BIT];

  // Receiver mode bits
  assign CONTINUOUS_READBACK_READBACK = rdbk_r[apfc_pkg::CONTINUOUS_READBACK_BIT];
  assign FLAGS_APPEND  = rdbk_r[apfc_pkg::FLAGS_BIT];
  assign HIGH_RATE_EN  = rdbk_r[apfc_pkg::HIRATE_BIT];

  // Truncation to the received word length unless masked off
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      smp_r   <= 24'h000000;
      smp_v_r <= 1'b0;
    end
    else
    begin
      smp_v_r <= RX_SAMPLE_VALID;
      if (RX_SAMPLE_VALID)
      begin
        if (rdbk_r[apfc_pkg::TRMASK_BIT])
          smp_r <= RX_SAMPLE_IN;
        else
          smp_r <= RX_SAMPLE_IN & keep_mask(CS_WORD_BITS);
      end
    end
  end

  assign RX_SAMPLE_OUT       = smp_r;
  assign RX_SAMPLE_OUT_VALID = smp_v_r;

  // Flag pin routing
  assign fif.flags    = sync2_r[12:0];
  assign fif.sel0     = flag0_r[apfc_pkg::SEL0_LSB +: 4];
  assign fif.sel1     = flag1_r[apfc_pkg::SEL0_LSB +: 4];
  assign fif.sel2     = flag2_r[apfc_pkg::SEL2_LSB +: 4];
  assign fif.two_wire = sync2_r[14];
  assign GPO_O        = fif.pin;
  assign GPO_OE       = fif.oe;

  apfc_flag_mux u_flag_mux (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .fi    (fif.mux)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  fmt_write_a: assert property (
    wr_acc && idx == apfc_pkg::IDX_TXFMT |=> TX_FORMAT == $past(AVS_WRITEDATA[1:0]))
    else $error("transmit format not taken from write");
  wl_code_a: assert property (
    rxfmt_r[3:2] == 2'h3 |-> RX_WORD_BITS == 5'h18)
    else $error("word length code 11 not 24 bits");
  bclk_inv_a: assert property (
    master && txfmt_r[4] |=> TX_BCLK == !$past(BCLK_GEN))
    else $error("transmit bit clock not inverted");
  lr_inv_a: assert property (
    master && rxfmt_r[5] && RX_FORMAT == 2'h2 |=> RX_LRCLK == !$past(LRCLK_GEN))
    else $error("receive frame clock not inverted");
  slave_hiz_a: assert property (
    !master |=> !BCLK_OE && !LRCLK_OE)
    else $error("audio clocks driven in slave mode");
  loss_stop_a: assert property (
    master && src_lost && !rxfmt_r[7] |=> !BCLK_OE)
    else $error("clocks still driven after source loss");
  sel_read_a: assert property (
    AVS_READ && !ack_r && idx == apfc_pkg::IDX_RDATA && rdbk_r[2:0] == 3'h1
    |=> AVS_READDATA[7:0] == $past(RX_STATUS[15:8]))
    else $error("readback does not return channel status 1");
  mode_bits_a: assert property (
    wr_acc && idx == apfc_pkg::IDX_RDBK |=> CONTINUOUS_READBACK_READBACK == $past(AVS_WRITEDATA[3])
    && FLAGS_APPEND == $past(AVS_WRITEDATA[4]) && HIGH_RATE_EN == $past(AVS_WRITEDATA[7]))
    else $error("readback mode bits not taken from write");
  no_trunc_a: assert property (
    RX_SAMPLE_VALID && rdbk_r[6] |=> RX_SAMPLE_OUT == $past(RX_SAMPLE_IN))
    else $error("sample truncated while mask set");
  unused_zero_a: assert property (
    AVS_READ && !ack_r && idx == apfc_pkg::IDX_TXFMT |=> AVS_READDATA[31:6] == 26'h0)
    else $error("unused bits read non-zero");
  set_wins_a: assert property (
    ievt[0] |=> istat_r[0])
    else $error("interrupt event lost");
  wait_one_a: assert property (
    req && !ack_r |=> !AVS_WAITREQUEST [*1])
    else $error("bus access not answered after one wait");

  irq_seen_c: cover property (IRQ);
  loss_kept_c: cover property (master && src_lost && BCLK_OE);
  rdbk_read_c: cover property (acc && AVS_READ && idx == apfc_pkg::IDX_RDATA);
  trunc_c: cover property (smp_v_r && !rdbk_r[6] && CS_WORD_BITS == 5'h10);
endmodule : apfc_top

// file: sim/apfc_host.sv
module apfc_host (
  // Bus clock
  input  wire logic        clk,
  // Avalon-MM answer
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  // Avalon-MM request
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus from time zero, so reset never sees a request
  initial
  begin
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h00000000;
    byteenable = 4'h0;
  end

  // One access; the extra leading edge keeps back-to-back calls from
  // lowering and raising a strobe in the same time step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
    @(posedge clk);
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= be;
    write      <= w;
    read       <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    q = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
  endtask : xfer
endmodule : apfc_host

// file: sim/audio_port_flag_config_test.sv
module audio_port_flag_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS = 1'b0;
  logic        NRST = 1'b0;
  logic [7:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic        AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, RX_SRC_LOST, CTRL_TWO_WIRE;
  logic [12:0] RX_FLAGS;
  logic [55:0] RX_STATUS;
  logic [4:0]  CS_WORD_BITS, TX_WORD_BITS, RX_WORD_BITS, w;
  logic [23:0] RX_SAMPLE_IN, RX_SAMPLE_OUT;
  logic        RX_SAMPLE_VALID, RX_SAMPLE_OUT_VALID, BCLK_GEN, LRCLK_GEN, BCLK_I, LRCLK_I;
  logic        BCLK_O, BCLK_OE, LRCLK_O, LRCLK_OE, TX_BCLK, TX_LRCLK, TX_DSP_B, b;
  logic        RX_BCLK, RX_LRCLK, RX_DSP_B, CONTINUOUS_READBACK_READBACK, FLAGS_APPEND, HIGH_RATE_EN;
  logic [2:0]  GPO_O, GPO_OE;
  logic [1:0]  TX_FORMAT, RX_FORMAT, f;
  logic [9:0]  e;
  logic [7:0]  q;
  logic [31:0] seed = 32'h0000003C;
  int          error_cnt = 0;
  int          num_checks = 0;
  // Register model: byte address, writable bits, current value (starts at reset)
  logic [7:0]  ra [6] = '{8'h5C, 8'h60, 8'h68, 8'h6C, 8'h70, 8'h74};
  logic [7:0]  rm [6] = '{apfc_pkg::MSK_FLAG0, apfc_pkg::MSK_FLAG1, apfc_pkg::MSK_FLAG2,
                          apfc_pkg::MSK_TXFMT, apfc_pkg::MSK_RXFMT, apfc_pkg::MSK_RDBK};
  logic [7:0]  rv [6] = '{8'h00, 8'h07, 8'h40, 8'h06, 8'h06, 8'h80};

  apfc_top u_apfc_top (.CLK_SYS, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ, .RX_FLAGS, .RX_SRC_LOST,
    .RX_STATUS, .CS_WORD_BITS, .RX_SAMPLE_IN, .RX_SAMPLE_VALID, .CTRL_TWO_WIRE, .BCLK_GEN,
    .LRCLK_GEN, .BCLK_I, .BCLK_O, .BCLK_OE, .LRCLK_I, .LRCLK_O, .LRCLK_OE, .GPO_O, .GPO_OE,
    .TX_FORMAT, .TX_WORD_BITS, .TX_BCLK, .TX_LRCLK, .TX_DSP_B, .RX_FORMAT, .RX_WORD_BITS,
    .RX_BCLK, .RX_LRCLK, .RX_DSP_B, .CONTINUOUS_READBACK_READBACK, .FLAGS_APPEND, .HIGH_RATE_EN,
    .RX_SAMPLE_OUT, .RX_SAMPLE_OUT_VALID);

  apfc_host u_apfc_host (.clk(CLK_SYS), .waitrequest(AVS_WAITREQUEST),
    .readdata(AVS_READDATA), .address(AVS_ADDRESS), .read(AVS_READ), .write(AVS_WRITE),
    .writedata(AVS_WRITEDATA), .byteenable(AVS_BYTEENABLE));

  // 100 MHz system clock
  always #5 CLK_SYS = ~CLK_SYS;

  // Pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Compare one result against the model
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Write through the host; model follows only when byte lane 0 is on
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    u_apfc_host.xfer(1'b1, a, d, be, q);
    for (int i = 0; i < 6; i++)
      if (ra[i] == a && be[0])
        rv[i] = d & rm[i];
  endtask : wr

  // Read through the host and compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
    u_apfc_host.xfer(1'b0, a, 8'h00, 4'hF, q);
    chk(q, ex, "register read");
  endtask : rdc

  // Settle time after a change, long enough for the two-stage synchronisers
  task automatic settle();
    repeat (4) @(posedge CLK_SYS);
    #1;
  endtask : settle

  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog: the whole sequence needs about a thousand cycles
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    {RX_FLAGS, RX_SRC_LOST, RX_STATUS, CS_WORD_BITS, RX_SAMPLE_IN, RX_SAMPLE_VALID} <= '0;
    {CTRL_TWO_WIRE, BCLK_GEN, LRCLK_GEN, BCLK_I, LRCLK_I} <= '0;
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(ra[i], rv[i]);
    // Reset selectors with all flags high: only pin 0 outside two-wire mode
    RX_FLAGS <= 13'h1FFF;
    settle();
    chk({GPO_OE, GPO_O}, 32'h09, "one-pin mode");
    // Inputs only move on a rising edge
    @(posedge CLK_SYS);
    CTRL_TWO_WIRE <= 1'b1;
    settle();
    chk({GPO_OE, GPO_O}, 32'h3F, "two-wire mode");
    seed = xs(seed);
    @(posedge CLK_SYS);
    RX_FLAGS <= seed[12:0];
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h5C, c[7:0], 4'h1);
      wr(8'h60, c[7:0], 4'h1);
      wr(8'h68, {c[3:0], 4'h0}, 4'h1);
      settle();
      b = (c < 13) ? RX_FLAGS[c] : 1'b0;
      chk({GPO_OE, GPO_O}, {3'h7, {3{b}}}, "flag pin code");
    end
    // Random writes, ignored byte lane, unmapped place
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr(ra[i], seed[7:0], 4'h1);
      wr(ra[i], ~seed[7:0], 4'h0);
      rdc(ra[i], rv[i]);
    end
    wr(8'h40, 8'hFF, 4'h1);
    rdc(8'h40, 8'h00);
    // Every port setting in slave mode with static pin clocks
    BCLK_I <= 1'b1;
    LRCLK_I <= 1'b1;
    for (int v = 0; v < 64; v++)
    begin
      wr(8'h6C, v[7:0], 4'h1);
      wr(8'h70, v[7:0], 4'h1);
      settle();
      f = v[1:0];
      w = (v[3:2] == 0) ? 5'h10 : (v[3:2] == 1) ? 5'h14 : 5'h18;
      e = {f, w, ~v[4], ~(v[5] & (f != 2'h3)), v[5] & (f == 2'h3)};
      chk({TX_FORMAT, TX_WORD_BITS, TX_BCLK, TX_LRCLK, TX_DSP_B}, e, "tx port");
      chk({RX_FORMAT, RX_WORD_BITS, RX_BCLK, RX_LRCLK, RX_DSP_B, BCLK_OE, LRCLK_OE},
          {e, 2'b00}, "rx port");
    end
    // Readback selector and mode levels
    seed = xs(seed);
    @(posedge CLK_SYS);
    RX_STATUS <= {seed[23:0], xs(seed)};
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h74, {s[0], 2'b00, s[1], s[2], s[2:0]}, 4'h1);
      #1;
      chk({CONTINUOUS_READBACK_READBACK, FLAGS_APPEND, HIGH_RATE_EN}, s[2:0], "mode levels");
      rdc(8'h88, (s < 7) ? RX_STATUS[8 * s +: 8] : 8'h00);
      rdc(8'h74, rv[5]);
    end
    // Sample truncation, then pass-through
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h74, {1'b1, m[0], 6'h00}, 4'h1);
      seed = xs(seed);
      CS_WORD_BITS <= 5'h10 + seed[26:24];
      RX_SAMPLE_IN <= seed[23:0];
      RX_SAMPLE_VALID <= 1'b1;
      @(posedge CLK_SYS);
      RX_SAMPLE_VALID <= 1'b0;
      #1;
      chk({RX_SAMPLE_OUT_VALID, RX_SAMPLE_OUT}, {1'b1, m ? seed[23:0] :
          seed[23:0] & ~(24'hFFFFFF >> (16 + seed[26:24]))}, "sample");
    end
    // Master clocks, source loss, interrupt raise, mask and clear
    wr(8'h84, 8'h01, 4'h1);
    BCLK_GEN <= 1'b1;
    LRCLK_GEN <= 1'b1;
    wr(8'h70, 8'h62, 4'h1);
    settle();
    chk({BCLK_OE, LRCLK_OE, BCLK_O, LRCLK_O, IRQ}, 32'h1E, "master out");
    // Flags low now, so the update flag later gives a clean rising edge
    @(posedge CLK_SYS);
    RX_SRC_LOST <= 1'b1;
    RX_FLAGS <= 13'h0000;
    settle();
    chk({BCLK_OE, LRCLK_OE, IRQ}, 32'h1, "clocks stop on loss");
    // Update flag bit has been pending since the flags first went high
    rdc(8'h80, 8'h03);
    wr(8'h70, 8'hE2, 4'h1);
    wr(8'h80, 8'h03, 4'h1);
    settle();
    chk({BCLK_OE, LRCLK_OE, IRQ}, 32'h6, "clocks kept on loss");
    @(posedge CLK_SYS);
    RX_FLAGS <= 13'h0200;
    settle();
    rdc(8'h80, 8'h02);
    chk(IRQ, 32'h0, "masked event");
    wr(8'h84, 8'h02, 4'h1);
    #1;
    chk(IRQ, 32'h1, "unmasked event");
    wr(8'h80, 8'h02, 4'h1);
    #1;
    chk(IRQ, 32'h0, "event cleared");
    rdc(8'h80, 8'h00);
    print_verdict();
  end
endmodule : audio_port_flag_config_test
